// >>> hdl/ivpm_top.sv
`timescale 1ns/1ps
`include "ivpm_params.svh"
module ivpm_top (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [1:0] variant,
  input wire logic hard_reset_in,
  input wire logic soft_reset_trap,
  input wire logic nmi_irq,
  input wire logic ext_user_irq0,
  input wire logic ext_user_irq1,
  input wire logic ext_user_irq2,
  input wire logic ext_user_irq3,
  input wire logic timer_irq,
  input wire logic buffered_port_rx_irq,
  input wire logic buffered_port_tx_irq,
  input wire logic multiplexed_port_rx_irq,
  input wire logic multiplexed_port_tx_irq,
  input wire logic second_port_rx_irq,
  input wire logic second_port_tx_irq,
  input wire logic host_port_irq,
  input wire logic sw_trap_req,
  input wire logic [4:0] sw_trap_num,
  input wire logic ptr_wr,
  input wire logic [8:0] ptr_wdata,
  input wire logic vec_ack,
  output logic vec_valid,
  output ivpm_pkg::ivpm_vec_t vec_out,
  output logic [8:0] vector_page_pointer,
  output logic [`IVPM_NUM_HW-1:0] pending_out
);
  // two-flop synchronisers for the interrupt request pins, three flops for hard_reset_in
  logic [`IVPM_NUM_HW-1:0] raw;
  logic [`IVPM_NUM_HW-1:0] meta_r;
  logic [`IVPM_NUM_HW-1:0] sync_r;
  logic [`IVPM_NUM_HW-1:0] prev_r;
  logic [`IVPM_NUM_HW-1:0] pend_r, pend_nxt;
  logic [1:0] hrst_meta_r;
  logic hrst_sync_r, hrst_prev_r;
  logic [8:0] ptr_r, ptr_nxt;
  ivpm_pkg::ivpm_state_t state_r, state_nxt;
  ivpm_pkg::ivpm_vec_t vec_r, vec_nxt;
  logic [4:0] hw_trap [`IVPM_NUM_HW];
  logic [3:0] hw_prio [`IVPM_NUM_HW];
  logic [4:0] sel_trap;
  logic [3:0] best_prio;
  logic [`IVPM_NUM_HW-1:0] best_bit;
  logic any_hw;
  logic [`IVPM_NUM_HW-1:0] enabled;
  logic [`IVPM_NUM_HW-1:0] clr;
  ivpm_pkg::ivpm_entry_t sel_entry;
  logic hard_rst_evt, take_rst, take_hw, take_sw;
  logic [15:0] sel_addr;

  always_comb begin
    raw = '0;
    raw[`IVPM_HW_NMI] = nmi_irq;
    raw[`IVPM_HW_EXT_USER_IRQ0] = ext_user_irq0;
    raw[`IVPM_HW_EXT_USER_IRQ1] = ext_user_irq1;
    raw[`IVPM_HW_EXT_USER_IRQ2] = ext_user_irq2;
    raw[`IVPM_HW_TIMER] = timer_irq;
    raw[`IVPM_HW_BRX] = buffered_port_rx_irq;
    raw[`IVPM_HW_BTX] = buffered_port_tx_irq;
    raw[`IVPM_HW_MRX] = multiplexed_port_rx_irq;
    // request slot 8 (trap 23) carries whichever transmit port this variant really has
    if (variant == `IVPM_VAR_TDM) begin
      raw[`IVPM_HW_MTX] = multiplexed_port_tx_irq;
    end else begin
      raw[`IVPM_HW_MTX] = second_port_tx_irq;
    end
    raw[`IVPM_HW_EXT_USER_IRQ3] = ext_user_irq3;
    raw[`IVPM_HW_HPI] = host_port_irq;
    raw[`IVPM_HW_SRX] = second_port_rx_irq;
  end

  // which sources exist in the selected variant; the two transmit ports
  // share one slot, chosen by variant above, so that slot stays enabled
  always_comb begin
    enabled = '1;
    if (variant == `IVPM_VAR_TDM) begin
      enabled[`IVPM_HW_SRX] = 1'b0;
      enabled[`IVPM_HW_HPI] = 1'b0;
    end else begin
      enabled[`IVPM_HW_MRX] = 1'b0;
      if (variant != `IVPM_VAR_STD_HPI) begin
        enabled[`IVPM_HW_HPI] = 1'b0;
      end
    end
  end

  // trap and priority per request bit
  always_comb begin
    hw_trap[`IVPM_HW_NMI] = `IVPM_TRAP_NMI;
    hw_trap[`IVPM_HW_EXT_USER_IRQ0] = `IVPM_TRAP_EXT_USER_IRQ0;
    hw_trap[`IVPM_HW_EXT_USER_IRQ1] = `IVPM_TRAP_EXT_USER_IRQ1;
    hw_trap[`IVPM_HW_EXT_USER_IRQ2] = `IVPM_TRAP_EXT_USER_IRQ2;
    hw_trap[`IVPM_HW_TIMER] = `IVPM_TRAP_TIMER;
    hw_trap[`IVPM_HW_BRX] = `IVPM_TRAP_BRX;
    hw_trap[`IVPM_HW_BTX] = `IVPM_TRAP_BTX;
    hw_trap[`IVPM_HW_MRX] = `IVPM_TRAP_P1RX;
    hw_trap[`IVPM_HW_MTX] = `IVPM_TRAP_P1TX;
    hw_trap[`IVPM_HW_EXT_USER_IRQ3] = `IVPM_TRAP_EXT_USER_IRQ3;
    hw_trap[`IVPM_HW_HPI] = `IVPM_TRAP_HPI;
    hw_trap[`IVPM_HW_SRX] = `IVPM_TRAP_P1RX;
    hw_prio[`IVPM_HW_NMI] = `IVPM_PRI_NMI;
    hw_prio[`IVPM_HW_EXT_USER_IRQ0] = `IVPM_PRI_EXT_USER_IRQ0;
    hw_prio[`IVPM_HW_EXT_USER_IRQ1] = `IVPM_PRI_EXT_USER_IRQ1;
    hw_prio[`IVPM_HW_EXT_USER_IRQ2] = `IVPM_PRI_EXT_USER_IRQ2;
    hw_prio[`IVPM_HW_TIMER] = `IVPM_PRI_TIMER;
    hw_prio[`IVPM_HW_BRX] = `IVPM_PRI_BRX;
    hw_prio[`IVPM_HW_BTX] = `IVPM_PRI_BTX;
    hw_prio[`IVPM_HW_MRX] = `IVPM_PRI_P1RX;
    hw_prio[`IVPM_HW_MTX] = `IVPM_PRI_P1TX;
    hw_prio[`IVPM_HW_EXT_USER_IRQ3] = `IVPM_PRI_EXT_USER_IRQ3;
    hw_prio[`IVPM_HW_HPI] = `IVPM_PRI_HPI;
    hw_prio[`IVPM_HW_SRX] = `IVPM_PRI_P1RX;
  end

  // synchronisers; only sync_r feeds the edge detect
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
      hrst_meta_r <= 2'b00;
      hrst_sync_r <= 1'b0;
      hrst_prev_r <= 1'b0;
    end else begin
      meta_r <= raw;
      sync_r <= meta_r;
      prev_r <= sync_r;
      hrst_meta_r <= {hrst_meta_r[0], hard_reset_in};
      hrst_sync_r <= hrst_meta_r[1];
      hrst_prev_r <= hrst_sync_r;
    end
  end

  assign hard_rst_evt = hrst_sync_r & ~hrst_prev_r;

  // lowest priority value among pending wins
  always_comb begin
    best_prio = '1;
    best_bit = '0;
    any_hw = 1'b0;
    for (int i = 0; i < `IVPM_NUM_HW; i++) begin
      if (pend_r[i] && hw_prio[i] < best_prio) begin
        best_prio = hw_prio[i];
        best_bit = '0;
        best_bit[i] = 1'b1;
        any_hw = 1'b1;
      end
    end
    sel_trap = `IVPM_TRAP_RESET;
    for (int i = 0; i < `IVPM_NUM_HW; i++) begin
      if (best_bit[i]) begin
        sel_trap = hw_trap[i];
      end
    end
  end

  // reset beats hardware, hardware beats a software trap
  assign take_rst = (state_r == ivpm_pkg::IVPM_IDLE) && (hard_rst_evt || soft_reset_trap);
  assign take_hw = (state_r == ivpm_pkg::IVPM_IDLE) && !take_rst && any_hw;
  assign take_sw = (state_r == ivpm_pkg::IVPM_IDLE) && !take_rst && !any_hw && sw_trap_req;

  ivpm_map u_map (
    .variant(variant),
    .trap(take_rst ? `IVPM_TRAP_RESET : (take_hw ? sel_trap : sw_trap_num)),
    .entry(sel_entry)
  );

  // page pointer forms the upper address bits
  assign sel_addr = {ptr_nxt, sel_entry.offset};

  always_comb begin
    pend_nxt = pend_r;
    ptr_nxt = ptr_r;
    state_nxt = state_r;
    vec_nxt = vec_r;
    clr = take_hw ? best_bit : '0;
    if (hard_rst_evt) begin
      ptr_nxt = `IVPM_PTR_RESET;
    end else if (ptr_wr) begin
      ptr_nxt = ptr_wdata;
    end
    // a new edge in the serve cycle wins over the clear
    pend_nxt = ((pend_r & ~clr) | (sync_r & ~prev_r)) & enabled;
    case (state_r)
      ivpm_pkg::IVPM_IDLE: begin
        if (take_rst || take_hw || (take_sw && sel_entry.valid)) begin
          vec_nxt.trap = take_rst ? `IVPM_TRAP_RESET : (take_hw ? sel_trap : sw_trap_num);
          vec_nxt.addr = sel_addr;
          state_nxt = ivpm_pkg::IVPM_WAIT_ACK;
        end
      end
      ivpm_pkg::IVPM_WAIT_ACK: begin
        if (vec_ack) begin
          state_nxt = ivpm_pkg::IVPM_IDLE;
        end
      end
      default: state_nxt = ivpm_pkg::IVPM_IDLE;
    endcase
  end

  // register stage for pending, pointer and handed-out vector
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pend_r <= '0;
      ptr_r <= `IVPM_PTR_RESET;
      state_r <= ivpm_pkg::IVPM_IDLE;
      vec_r <= '0;
    end else begin
      pend_r <= pend_nxt;
      ptr_r <= ptr_nxt;
      state_r <= state_nxt;
      vec_r <= vec_nxt;
    end
  end

  assign vec_valid = (state_r == ivpm_pkg::IVPM_WAIT_ACK);
  assign vec_out = vec_r;
  assign vector_page_pointer = ptr_r;
  assign pending_out = pend_r;
endmodule

// >>> hdl/ivpm_params.svh
`ifndef IVPM_PARAMS_SVH
`define IVPM_PARAMS_SVH
// variant codes
`define IVPM_VAR_TDM 2'h0
`define IVPM_VAR_STD 2'h1
`define IVPM_VAR_STD_HPI 2'h2
// trap numbers
`define IVPM_TRAP_RESET 5'h00
`define IVPM_TRAP_NMI 5'h01
`define IVPM_TRAP_SW_FIRST 5'h02
`define IVPM_TRAP_SW_RSVD0 5'h0E
`define IVPM_TRAP_SW_RSVD1 5'h0F
`define IVPM_TRAP_EXT_USER_IRQ0 5'h10
`define IVPM_TRAP_EXT_USER_IRQ1 5'h11
`define IVPM_TRAP_EXT_USER_IRQ2 5'h12
`define IVPM_TRAP_TIMER 5'h13
`define IVPM_TRAP_BRX 5'h14
`define IVPM_TRAP_BTX 5'h15
`define IVPM_TRAP_P1RX 5'h16
`define IVPM_TRAP_P1TX 5'h17
`define IVPM_TRAP_EXT_USER_IRQ3 5'h18
`define IVPM_TRAP_HPI 5'h19
// priorities, lower value served first, 0 means none
`define IVPM_PRI_NONE 4'h0
`define IVPM_PRI_RESET 4'h1
`define IVPM_PRI_NMI 4'h2
`define IVPM_PRI_EXT_USER_IRQ0 4'h3
`define IVPM_PRI_EXT_USER_IRQ1 4'h4
`define IVPM_PRI_EXT_USER_IRQ2 4'h5
`define IVPM_PRI_TIMER 4'h6
`define IVPM_PRI_BRX 4'h7
`define IVPM_PRI_BTX 4'h8
`define IVPM_PRI_P1RX 4'h9
`define IVPM_PRI_P1TX 4'hA
`define IVPM_PRI_EXT_USER_IRQ3 4'hB
`define IVPM_PRI_HPI 4'hC
// vector page pointer
`define IVPM_PTR_RESET 9'h1FF
`define IVPM_OFS_SHIFT 2
// hardware request bit positions
`define IVPM_NUM_HW 12
`define IVPM_HW_NMI 0
`define IVPM_HW_EXT_USER_IRQ0 1
`define IVPM_HW_EXT_USER_IRQ1 2
`define IVPM_HW_EXT_USER_IRQ2 3
`define IVPM_HW_TIMER 4
`define IVPM_HW_BRX 5
`define IVPM_HW_BTX 6
`define IVPM_HW_MRX 7
`define IVPM_HW_MTX 8
`define IVPM_HW_EXT_USER_IRQ3 9
`define IVPM_HW_HPI 10
`define IVPM_HW_SRX 11
`endif

// >>> hdl/ivpm_pkg.sv
package ivpm_pkg;
  // one table entry
  typedef struct packed {
    logic valid;
    logic hw;
    logic reserved;
    logic [3:0] prio;
    logic [6:0] offset;
  } ivpm_entry_t;
  // vector handed to the core
  typedef struct packed {
    logic [4:0] trap;
    logic [15:0] addr;
  } ivpm_vec_t;
  typedef enum logic [1:0] {
    IVPM_IDLE,
    IVPM_WAIT_ACK
  } ivpm_state_t;
endpackage

// >>> hdl/ivpm_map.sv
`timescale 1ns/1ps
`include "ivpm_params.svh"
// pure lookup: trap number to priority and offset for one variant
module ivpm_map (
  input wire logic [1:0] variant,
  input wire logic [4:0] trap,
  output ivpm_pkg::ivpm_entry_t entry
);
  logic [3:0] prio;
  logic hw;
  logic rsvd;
  logic valid;

  // offset is always trap times four; priority and the valid, hw and reserved flags differ
  always_comb begin
    prio = `IVPM_PRI_NONE;
    hw = 1'b1;
    rsvd = 1'b0;
    valid = 1'b1;
    if (trap == `IVPM_TRAP_RESET) begin
      prio = `IVPM_PRI_RESET;
    end else if (trap == `IVPM_TRAP_NMI) begin
      prio = `IVPM_PRI_NMI;
    end else if (trap < `IVPM_TRAP_EXT_USER_IRQ0) begin
      hw = 1'b0;
      rsvd = (trap == `IVPM_TRAP_SW_RSVD0) || (trap == `IVPM_TRAP_SW_RSVD1);
    end else if (trap == `IVPM_TRAP_EXT_USER_IRQ0) begin
      prio = `IVPM_PRI_EXT_USER_IRQ0;
    end else if (trap == `IVPM_TRAP_EXT_USER_IRQ1) begin
      prio = `IVPM_PRI_EXT_USER_IRQ1;
    end else if (trap == `IVPM_TRAP_EXT_USER_IRQ2) begin
      prio = `IVPM_PRI_EXT_USER_IRQ2;
    end else if (trap == `IVPM_TRAP_TIMER) begin
      prio = `IVPM_PRI_TIMER;
    end else if (trap == `IVPM_TRAP_BRX) begin
      prio = `IVPM_PRI_BRX;
    end else if (trap == `IVPM_TRAP_BTX) begin
      prio = `IVPM_PRI_BTX;
    end else if (trap == `IVPM_TRAP_P1RX) begin
      prio = `IVPM_PRI_P1RX;
    end else if (trap == `IVPM_TRAP_P1TX) begin
      prio = `IVPM_PRI_P1TX;
    end else if (trap == `IVPM_TRAP_EXT_USER_IRQ3) begin
      prio = `IVPM_PRI_EXT_USER_IRQ3;
    end else if (trap == `IVPM_TRAP_HPI && variant == `IVPM_VAR_STD_HPI) begin
      prio = `IVPM_PRI_HPI;
    end else begin
      hw = 1'b0;
      rsvd = 1'b1;
      valid = 1'b0;
    end
  end

  // one driver for the whole entry: valid, hw, reserved, prio, offset
  assign entry = {valid, hw, rsvd, prio, trap, 2'b00};
endmodule

// >>> verification/ivpm_checker.sv
`timescale 1ns/1ps
`include "ivpm_params.svh"
// protocol and mapping checks on the top ports
module ivpm_checker (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [1:0] variant,
  input wire logic hard_reset_in,
  input wire logic ext_user_irq0,
  input wire logic vec_ack,
  input wire logic vec_valid,
  input ivpm_pkg::ivpm_vec_t vec_out,
  input wire logic [8:0] vector_page_pointer,
  input wire logic [`IVPM_NUM_HW-1:0] pending_out
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_reset_ptr;
    $fell(rst) |-> vector_page_pointer == 9'h1FF && !vec_valid;
  endproperty
  a_reset_ptr: assert property (p_reset_ptr) else $error("pointer not reloaded");
  property p_hard_ptr;
    $rose(hard_reset_in) |-> ##[1:6] vector_page_pointer == 9'h1FF;
  endproperty
  a_hard_ptr: assert property (p_hard_ptr) else $error("hard reset kept pointer");
  // address formed from pointer and trap; skipped when the pointer moved at take
  property p_addr;
    $rose(vec_valid) && $stable(vector_page_pointer) |->
      vec_out.addr == {vector_page_pointer, vec_out.trap, 2'b00};
  endproperty
  a_addr: assert property (p_addr) else $error("vector address wrong");
  property p_hold;
    vec_valid && !vec_ack |=> vec_valid && $stable(vec_out);
  endproperty
  a_hold: assert property (p_hold) else $error("vector dropped early");
  property p_ack_drop;
    vec_valid && vec_ack |=> !vec_valid;
  endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("vector stuck after ack");
  property p_irq0;
    $rose(ext_user_irq0) |-> ##[1:4] pending_out[`IVPM_HW_EXT_USER_IRQ0];
  endproperty
  a_irq0: assert property (p_irq0) else $error("user line 0 not latched");
  property p_prio;
    $rose(vec_valid) && vec_out.trap == 5'h11 |-> !$past(pending_out[`IVPM_HW_EXT_USER_IRQ0]);
  endproperty
  a_prio: assert property (p_prio) else $error("line 1 beat line 0");
  property p_absent_tdm;
    variant == 2'h0 |-> !pending_out[`IVPM_HW_HPI] && !pending_out[`IVPM_HW_SRX];
  endproperty
  a_absent_tdm: assert property (p_absent_tdm) else $error("absent source pending");
  property p_absent_std;
    variant != 2'h0 |-> !pending_out[`IVPM_HW_MRX];
  endproperty
  a_absent_std: assert property (p_absent_std) else $error("absent port pending");
endmodule
bind ivpm_top ivpm_checker i_chk (.*);

// >>> verification/ivpm_core_model.sv
`timescale 1ns/1ps
// core side: acknowledges a waiting vector, promptly or after a stall
module ivpm_core_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic vec_valid,
  input wire logic slow,
  output logic vec_ack
);
  logic [3:0] cnt_r;
  // one-cycle ack; a stall of six cycles models a busy pipeline
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      vec_ack <= 1'b0;
      cnt_r <= 4'h0;
    end else begin
      vec_ack <= 1'b0;
      if (vec_valid && !vec_ack) begin
        cnt_r <= cnt_r + 4'h1;
        if (cnt_r >= (slow ? 4'h6 : 4'h0)) begin
          vec_ack <= 1'b1;
          cnt_r <= 4'h0;
        end
      end
    end
  end
endmodule

// >>> verification/test_interrupt_vector_priority_map.sv
`timescale 1ns/1ps
`include "ivpm_params.svh"
module test_interrupt_vector_priority_map;
  logic ref_clk, rst, hard_reset_in, soft_reset_trap, sw_trap_req, ptr_wr, slow;
  logic vec_ack, vec_valid;
  logic [1:0] variant;
  logic [4:0] sw_trap_num;
  logic [8:0] ptr_wdata, vector_page_pointer;
  logic [12:0] irq;
  logic [11:0] pending_out;
  ivpm_pkg::ivpm_vec_t vec_out;
  int mismatches, samples_checked;
  // irq bit order: nmi, user 0..2, timer, buffered rx/tx, mux rx/tx, user 3, host, second rx/tx
  logic [4:0] trap_of [13] = '{5'h01, 5'h10, 5'h11, 5'h12, 5'h13, 5'h14, 5'h15,
    5'h16, 5'h17, 5'h18, 5'h19, 5'h16, 5'h17};
  ivpm_top i_dut (.*, .nmi_irq(irq[0]), .ext_user_irq0(irq[1]), .ext_user_irq1(irq[2]),
    .ext_user_irq2(irq[3]), .timer_irq(irq[4]), .buffered_port_rx_irq(irq[5]),
    .buffered_port_tx_irq(irq[6]), .multiplexed_port_rx_irq(irq[7]),
    .multiplexed_port_tx_irq(irq[8]), .ext_user_irq3(irq[9]), .host_port_irq(irq[10]),
    .second_port_rx_irq(irq[11]), .second_port_tx_irq(irq[12]));
  ivpm_core_model i_core (.ref_clk(ref_clk), .rst(rst), .vec_valid(vec_valid),
    .slow(slow), .vec_ack(vec_ack));
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  task check(string what, logic [20:0] seen, logic [20:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // bounded wait for vec_valid to reach a level
  task wait_for(logic lvl);
    int n;
    n = 0;
    while (vec_valid !== lvl && n < 30) begin
      @(negedge ref_clk);
      n++;
    end
    if (vec_valid !== lvl) begin
      mismatches++;
      close_out;
    end
  endtask
  // requests dropped while the vector still waits, so nothing is taken twice
  task get_vec(logic [4:0] t, logic [8:0] p);
    wait_for(1'b1);
    check("vector", vec_out, {t, p, t, 2'b00});
    @(posedge ref_clk);
    {irq, sw_trap_req, soft_reset_trap, hard_reset_in, ptr_wr} <= '0;
    wait_for(1'b0);
  endtask
  task no_vec;
    repeat (8) @(negedge ref_clk);
    check("quiet", vec_valid, 21'h0);
    @(posedge ref_clk);
    {irq, sw_trap_req} <= '0;
  endtask
  task do_reset(logic [1:0] v);
    rst <= 1'b1;
    variant <= v;
    slow <= v[0];
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    @(negedge ref_clk);
    check("ptr", vector_page_pointer, 9'h1FF);
  endtask
  // every source once per variant; absent ones must stay silent
  task s_sources(logic [1:0] v);
    do_reset(v);
    for (int s = 0; s < 13; s++) begin
      @(posedge ref_clk);
      irq[s] <= 1'b1;
      if ((s == 7 || s == 8) ? v == 2'h0 : (s > 10) ? v != 2'h0 : (s == 10) ? v == 2'h2 : 1)
        get_vec(trap_of[s], 9'h1FF);
      else
        no_vec;
    end
  endtask
  task s_soft;
    for (int t = 2; t < 16; t++) begin
      @(posedge ref_clk);
      sw_trap_req <= 1'b1;
      sw_trap_num <= 5'(t);
      get_vec(5'(t), 9'h1FF);
    end
    @(posedge ref_clk);
    sw_trap_req <= 1'b1;
    sw_trap_num <= 5'h1A;
    no_vec;
  endtask
  // five lines at once come out in priority order
  task s_prio;
    @(posedge ref_clk);
    irq <= 13'h020F;
    get_vec(5'h01, 9'h1FF);
    get_vec(5'h10, 9'h1FF);
    get_vec(5'h11, 9'h1FF);
    get_vec(5'h12, 9'h1FF);
    get_vec(5'h18, 9'h1FF);
  endtask
  task s_reloc;
    @(posedge ref_clk);
    ptr_wr <= 1'b1;
    ptr_wdata <= 9'h001;
    @(posedge ref_clk);
    ptr_wr <= 1'b0;
    irq[3] <= 1'b1;
    get_vec(5'h12, 9'h001);
    @(posedge ref_clk);
    soft_reset_trap <= 1'b1;
    get_vec(5'h00, 9'h001);
    @(posedge ref_clk);
    hard_reset_in <= 1'b1;
    get_vec(5'h00, 9'h1FF);
    check("ptr", vector_page_pointer, 9'h1FF);
  endtask
  initial begin
    {rst, hard_reset_in, soft_reset_trap, sw_trap_req, ptr_wr, slow} = 6'h20;
    {variant, sw_trap_num, ptr_wdata, irq} = '0;
    for (int v = 0; v < 3; v++)
      s_sources(2'(v));
    s_soft;
    s_prio;
    s_reloc;
    close_out;
  end
endmodule
